// File: include/dmacil_pkg.sv
// package for the dma completion interrupt logic: channel map, latch bits, vectors
`default_nettype none
package dmacil_pkg;
    localparam int NUM_CH = 22;
    localparam int NUM_SP = 12;
    localparam int NUM_AUD = 8;
    localparam int CNT_W = 16;
    localparam int CP_W = 20;
    localparam int CP_IRQ_BIT = 19;
    localparam int CP_ADDR_W = 19;
    localparam int SPI_CH = 20;
    localparam int PAR_CH = 21;
    localparam int AUD_CH0 = 12;
    // core latch bits
    localparam int CORE_W = 17;
    localparam int CORE_AUD_HI = 11;
    localparam int CORE_SPI_HI = 12;
    localparam int CORE_SER1 = 14;
    localparam int CORE_SER3 = 15;
    localparam int CORE_SER5 = 16;
    // second latch bits
    localparam int SEC_W = 10;
    localparam int SEC_SER0 = 0;
    localparam int SEC_SER2 = 1;
    localparam int SEC_SER4 = 2;
    localparam int SEC_PAR = 3;
    localparam int SEC_AUD_LO = 6;
    localparam int SEC_SPI_LO = 9;
    // vectors
    localparam logic [7:0] VEC_NONE = 8'h00;
    localparam logic [7:0] VEC_AUD_HI = 8'h2C;
    localparam logic [7:0] VEC_SPI_HI = 8'h30;
    localparam logic [7:0] VEC_SER1 = 8'h38;
    localparam logic [7:0] VEC_SER3 = 8'h3C;
    localparam logic [7:0] VEC_SER5 = 8'h40;
    localparam logic [7:0] VEC_SER0 = 8'h44;
    localparam logic [7:0] VEC_SER2 = 8'h48;
    localparam logic [7:0] VEC_SER4 = 8'h4C;
    localparam logic [7:0] VEC_PAR = 8'h50;
    localparam logic [7:0] VEC_AUD_LO = 8'h5C;
    localparam logic [7:0] VEC_SPI_LO = 8'h74;
    localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;

    // per-channel software programming
    typedef struct packed {
        logic enable;
        logic chainEn;
        logic cntWrite;
        logic [CNT_W-1:0] cntData;
        logic cpWrite;
        logic [CP_W-1:0] cpData;
    } dmacil_chprog_t;

    typedef struct packed {
        logic [CORE_W-1:0] core;
        logic [SEC_W-1:0] second;
    } dmacil_irqvec_t;
endpackage
`default_nettype wire

// File: core/dmacil_top.sv
// completion, active-status and interrupt latch logic of a 22-channel dma engine
// Functional notes
// - twenty-two channels: spi, parallel, twelve serial, eight audio
// - whole blocks move, channels run concurrently
// - completion when count decrements to zero
// - active bit held during transfer, cleared after
// - audio active may assert unintentionally; tolerated
// - unchained block completion sets latch bit
// - chained: per-block flag selects every block/chain end
// - single-word buffer access raises channel interrupt
// - mask gates dispatch, latching continues
// - software zero count write never completes
// - writing one moves one word then completes
// - non-dma receive-ready and transmit-room interrupts
// - simultaneous port events latch independently
// - serial one channels 0,1 to core bit 14
// - serial 0,2,4 second bits; 3,5 core bits
// - spi channel 20 high or low priority
// - parallel channel 21 to second bit 3
// - audio channels 12-19 share high/low interrupt
// - latches reflect status regardless of servicing
// - status registers update one cycle later
// - per-block flag is chain pointer bit 19
`default_nettype none
module dmacil_top (
    // clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // per-channel programming
    input wire dmacil_pkg::dmacil_chprog_t chProg [dmacil_pkg::NUM_CH],
    // per-channel word transfer strobes from the peripherals
    input wire logic [dmacil_pkg::NUM_CH-1:0] wordDone,
    // chain reload request (next block loaded by the chain loader)
    input wire logic [dmacil_pkg::NUM_CH-1:0] chainReload,
    // non-dma buffer events
    input wire logic [dmacil_pkg::NUM_CH-1:0] rxAvail,
    input wire logic [dmacil_pkg::NUM_CH-1:0] txRoom,
    // priority options
    input wire logic spiHighPri,
    input wire logic audioHighPri,
    // masks and software clears
    input wire dmacil_pkg::dmacil_irqvec_t irqMask,
    input wire dmacil_pkg::dmacil_irqvec_t irqClear,
    input wire logic irqAck,
    // status outputs
    output logic [dmacil_pkg::NUM_CH-1:0] chanActive,
    output logic [dmacil_pkg::NUM_AUD-1:0] audioInputChannelActive,
    output dmacil_pkg::dmacil_irqvec_t irqLatch,
    output logic irqReq,
    output logic [7:0] irqVector
);
    localparam int N = dmacil_pkg::NUM_CH;
    localparam int CW = dmacil_pkg::CNT_W;

    logic [CW-1:0] count_reg [N];
    logic [CW-1:0] count_next [N];
    logic [N-1:0] run_reg;
    logic [N-1:0] run_next;
    logic [N-1:0] pciFlag_reg;
    logic [N-1:0] pciFlag_next;
    logic [N-1:0] chainPend_reg;
    logic [N-1:0] chainPend_next;
    logic [N-1:0] chEvent;
    logic [N-1:0] active_reg;
    dmacil_pkg::dmacil_irqvec_t latch_reg;
    dmacil_pkg::dmacil_irqvec_t latch_next;
    dmacil_pkg::dmacil_irqvec_t setVec;
    dmacil_pkg::dmacil_irqvec_t pending;
    logic irqReq_reg;
    logic [7:0] vector_reg;
    logic [7:0] vector_next;

    // channel engines: all channels evolve in parallel every cycle
    always_comb
    begin
        for (int i = 0; i < N; i++)
        begin
            count_next[i] = count_reg[i];
            run_next[i] = run_reg[i];
            pciFlag_next[i] = pciFlag_reg[i];
            chainPend_next[i] = chainPend_reg[i];
            chEvent[i] = 1'b0;
            if (chProg[i].cpWrite)
            begin
                pciFlag_next[i] = chProg[i].cpData[dmacil_pkg::CP_IRQ_BIT];
                chainPend_next[i] = |chProg[i].cpData[dmacil_pkg::CP_ADDR_W-1:0];
            end
            if (!chProg[i].enable && !chProg[i].chainEn)
                run_next[i] = 1'b0;
            if (chProg[i].cntWrite)
            begin
                // a zero write parks the channel silently
                count_next[i] = chProg[i].cntData;
                run_next[i] = chProg[i].enable && (chProg[i].cntData != dmacil_pkg::CNT_ZERO);
            end
            else if (chainReload[i] && chProg[i].chainEn)
            begin
                count_next[i] = chProg[i].cntData;
                run_next[i] = chProg[i].cntData != dmacil_pkg::CNT_ZERO;
            end
            // a finished chained block idles at zero until the loader reloads it
            else if (run_reg[i] && wordDone[i] && (count_reg[i] != dmacil_pkg::CNT_ZERO))
            begin
                count_next[i] = count_reg[i] - dmacil_pkg::CNT_ONE;
                if (count_reg[i] == dmacil_pkg::CNT_ONE)
                begin
                    run_next[i] = chProg[i].chainEn && chainPend_reg[i];
                    if (!chProg[i].chainEn || !chainPend_reg[i] || pciFlag_reg[i])
                        chEvent[i] = 1'b1;
                end
            end
            else if (!run_reg[i] && (rxAvail[i] || txRoom[i]))
                chEvent[i] = 1'b1;
        end
    end

    // map channel events onto shared latch bits by or
    always_comb
    begin
        logic audEv;
        audEv = |chEvent[dmacil_pkg::AUD_CH0 +: dmacil_pkg::NUM_AUD];
        setVec = '0;
        setVec.core[dmacil_pkg::CORE_SER1] = chEvent[0] | chEvent[1];
        setVec.second[dmacil_pkg::SEC_SER0] = chEvent[2] | chEvent[3];
        setVec.core[dmacil_pkg::CORE_SER3] = chEvent[4] | chEvent[5];
        setVec.second[dmacil_pkg::SEC_SER2] = chEvent[6] | chEvent[7];
        setVec.core[dmacil_pkg::CORE_SER5] = chEvent[8] | chEvent[9];
        setVec.second[dmacil_pkg::SEC_SER4] = chEvent[10] | chEvent[11];
        setVec.core[dmacil_pkg::CORE_SPI_HI] = chEvent[dmacil_pkg::SPI_CH] & spiHighPri;
        setVec.second[dmacil_pkg::SEC_SPI_LO] = chEvent[dmacil_pkg::SPI_CH] & ~spiHighPri;
        setVec.second[dmacil_pkg::SEC_PAR] = chEvent[dmacil_pkg::PAR_CH];
        setVec.core[dmacil_pkg::CORE_AUD_HI] = audEv & audioHighPri;
        setVec.second[dmacil_pkg::SEC_AUD_LO] = audEv & ~audioHighPri;
    end

    assign pending = latch_reg & irqMask;

    // latch: set wins over clear; ack clears the dispatched source
    always_comb
    begin
        dmacil_pkg::dmacil_irqvec_t ackVec;
        ackVec = '0;
        vector_next = dmacil_pkg::VEC_NONE;
        if (pending.core[dmacil_pkg::CORE_AUD_HI])
        begin
            ackVec.core[dmacil_pkg::CORE_AUD_HI] = 1'b1;
            vector_next = dmacil_pkg::VEC_AUD_HI;
        end
        else if (pending.core[dmacil_pkg::CORE_SPI_HI])
        begin
            ackVec.core[dmacil_pkg::CORE_SPI_HI] = 1'b1;
            vector_next = dmacil_pkg::VEC_SPI_HI;
        end
        else if (pending.core[dmacil_pkg::CORE_SER1])
        begin
            ackVec.core[dmacil_pkg::CORE_SER1] = 1'b1;
            vector_next = dmacil_pkg::VEC_SER1;
        end
        else if (pending.core[dmacil_pkg::CORE_SER3])
        begin
            ackVec.core[dmacil_pkg::CORE_SER3] = 1'b1;
            vector_next = dmacil_pkg::VEC_SER3;
        end
        else if (pending.core[dmacil_pkg::CORE_SER5])
        begin
            ackVec.core[dmacil_pkg::CORE_SER5] = 1'b1;
            vector_next = dmacil_pkg::VEC_SER5;
        end
        else if (pending.second[dmacil_pkg::SEC_SER0])
        begin
            ackVec.second[dmacil_pkg::SEC_SER0] = 1'b1;
            vector_next = dmacil_pkg::VEC_SER0;
        end
        else if (pending.second[dmacil_pkg::SEC_SER2])
        begin
            ackVec.second[dmacil_pkg::SEC_SER2] = 1'b1;
            vector_next = dmacil_pkg::VEC_SER2;
        end
        else if (pending.second[dmacil_pkg::SEC_SER4])
        begin
            ackVec.second[dmacil_pkg::SEC_SER4] = 1'b1;
            vector_next = dmacil_pkg::VEC_SER4;
        end
        else if (pending.second[dmacil_pkg::SEC_PAR])
        begin
            ackVec.second[dmacil_pkg::SEC_PAR] = 1'b1;
            vector_next = dmacil_pkg::VEC_PAR;
        end
        else if (pending.second[dmacil_pkg::SEC_AUD_LO])
        begin
            ackVec.second[dmacil_pkg::SEC_AUD_LO] = 1'b1;
            vector_next = dmacil_pkg::VEC_AUD_LO;
        end
        else if (pending.second[dmacil_pkg::SEC_SPI_LO])
        begin
            ackVec.second[dmacil_pkg::SEC_SPI_LO] = 1'b1;
            vector_next = dmacil_pkg::VEC_SPI_LO;
        end
        if (!irqAck)
            ackVec = '0;
        latch_next = setVec | (latch_reg & ~irqClear & ~ackVec);
    end

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            for (int i = 0; i < N; i++)
                count_reg[i] <= dmacil_pkg::CNT_ZERO;
            run_reg <= '0;
            pciFlag_reg <= '0;
            chainPend_reg <= '0;
            active_reg <= '0;
            latch_reg <= '0;
            irqReq_reg <= 1'b0;
            vector_reg <= dmacil_pkg::VEC_NONE;
        end
        else
        begin
            for (int i = 0; i < N; i++)
                count_reg[i] <= count_next[i];
            run_reg <= run_next;
            pciFlag_reg <= pciFlag_next;
            chainPend_reg <= chainPend_next;
            active_reg <= run_reg;
            latch_reg <= latch_next;
            irqReq_reg <= |pending;
            vector_reg <= vector_next;
        end
    end

    assign chanActive = active_reg;
    // audio active bits are plain copies; consumers must not infer intent from them
    assign audioInputChannelActive = active_reg[dmacil_pkg::AUD_CH0 +: dmacil_pkg::NUM_AUD];
    assign irqLatch = latch_reg;
    assign irqReq = irqReq_reg;
    assign irqVector = vector_reg;

    a_status_lag: assert property (@(posedge clock) disable iff (!rst_b)
        chanActive == $past(run_reg))
        else $error("active status not one cycle behind channel state");
    a_zero_write_quiet: assert property (@(posedge clock) disable iff (!rst_b)
        (chProg[dmacil_pkg::PAR_CH].cntWrite
         && chProg[dmacil_pkg::PAR_CH].cntData == dmacil_pkg::CNT_ZERO)
        |=> !run_reg[dmacil_pkg::PAR_CH] && !$rose(irqLatch.second[dmacil_pkg::SEC_PAR]))
        else $error("count write raised a completion");
    a_chain_wait: assert property (@(posedge clock) disable iff (!rst_b)
        (run_reg[0] && count_reg[0] == dmacil_pkg::CNT_ZERO && !chProg[0].cntWrite
         && !chainReload[0]) |=> count_reg[0] == dmacil_pkg::CNT_ZERO)
        else $error("idle chained channel kept counting");
    a_idle_event: assert property (@(posedge clock) disable iff (!rst_b)
        (!run_reg[2] && (rxAvail[2] || txRoom[2]) && !chProg[2].cntWrite && !chainReload[2])
        |=> irqLatch.second[dmacil_pkg::SEC_SER0])
        else $error("idle buffer event not latched");
    a_ser1_latch: assert property (@(posedge clock) disable iff (!rst_b)
        (chEvent[0] || chEvent[1]) |=> irqLatch.core[dmacil_pkg::CORE_SER1])
        else $error("serial one completion not latched");
    a_par_latch: assert property (@(posedge clock) disable iff (!rst_b)
        chEvent[dmacil_pkg::PAR_CH] |=> irqLatch.second[dmacil_pkg::SEC_PAR])
        else $error("parallel completion not latched");
    a_spi_route: assert property (@(posedge clock) disable iff (!rst_b)
        (chEvent[dmacil_pkg::SPI_CH] && spiHighPri) |=> irqLatch.core[dmacil_pkg::CORE_SPI_HI])
        else $error("spi high priority not latched");

    // priority-selected sources set the chosen latch; request matches a non-idle vector
    a_spi_low: assert property (@(posedge clock) disable iff (!rst_b)
        (chEvent[dmacil_pkg::SPI_CH] && !spiHighPri) |=> irqLatch.second[dmacil_pkg::SEC_SPI_LO])
        else $error("spi low priority not latched");
    a_audio_high: assert property (@(posedge clock) disable iff (!rst_b)
        (|chEvent[dmacil_pkg::AUD_CH0 +: dmacil_pkg::NUM_AUD] && audioHighPri)
        |=> irqLatch.core[dmacil_pkg::CORE_AUD_HI])
        else $error("audio high priority not latched");
    a_audio_low: assert property (@(posedge clock) disable iff (!rst_b)
        (|chEvent[dmacil_pkg::AUD_CH0 +: dmacil_pkg::NUM_AUD] && !audioHighPri)
        |=> irqLatch.second[dmacil_pkg::SEC_AUD_LO])
        else $error("audio low priority not latched");
    a_vector_idle: assert property (@(posedge clock) disable iff (!rst_b)
        irqReq == (irqVector != dmacil_pkg::VEC_NONE))
        else $error("request and vector disagree");

    a_mask_gate: assert property (@(posedge clock) disable iff (!rst_b)
        irqReq == $past(|(irqLatch & irqMask)))
        else $error("request does not follow masked latch");
    a_latch_hold: assert property (@(posedge clock) disable iff (!rst_b)
        (irqLatch.core[dmacil_pkg::CORE_SER3] && !irqClear.core[dmacil_pkg::CORE_SER3]
         && !irqAck) |=> irqLatch.core[dmacil_pkg::CORE_SER3])
        else $error("latched bit dropped without clear");
    a_last_word: assert property (@(posedge clock) disable iff (!rst_b)
        (run_reg[4] && wordDone[4] && count_reg[4] == dmacil_pkg::CNT_ONE
         && !chProg[4].cntWrite && !chainReload[4] && !chProg[4].chainEn)
        |=> irqLatch.core[dmacil_pkg::CORE_SER3] ##1 !chanActive[4])
        else $error("final word did not complete channel");
    c_audio_hi: cover property (@(posedge clock) disable iff (!rst_b)
        irqLatch.core[dmacil_pkg::CORE_AUD_HI]);
    c_two_at_once: cover property (@(posedge clock) disable iff (!rst_b)
        chEvent[0] && chEvent[dmacil_pkg::PAR_CH]);
    c_dispatch: cover property (@(posedge clock) disable iff (!rst_b) irqReq && irqAck);
    // scenario covers for chained blocks and early stop
    c_chain_block: cover property (@(posedge clock) disable iff (!rst_b)
        chEvent[0] && chProg[0].chainEn);
    c_early_stop: cover property (@(posedge clock) disable iff (!rst_b)
        chEvent[dmacil_pkg::PAR_CH] && run_reg[dmacil_pkg::PAR_CH]);
endmodule
`default_nettype wire

// File: verif/dmacil_periph_model.sv
// peripheral-side model: moves words on running channels at a fast or slow pace
`default_nettype none
module dmacil_periph_model (
    // clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // pace control from the bench
    input wire logic [21:0] go,
    input wire logic slow,
    // engine side
    input wire logic [21:0] chanActive,
    output logic [21:0] wordDone
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] pace;
    // slow pace leaves three idle cycles so a stray extra word would be visible
    always @(posedge clock or negedge rst_b)
        if (!rst_b)
        begin
            pace <= 2'h0;
            wordDone <= 22'h0;
        end
        else
        begin
            pace <= pace + 2'h1;
            wordDone <= #1 go & chanActive & {22{!slow || pace == 2'h0}};
        end
endmodule
`default_nettype wire

// File: verif/dma_completion_interrupt_logic_tb.sv
// self-checking bench for the dma completion interrupt logic
`default_nettype none
module dma_completion_interrupt_logic_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    dmacil_pkg::dmacil_chprog_t chProg [dmacil_pkg::NUM_CH];
    logic [21:0] chainReload = 22'h0, rxAvail = 22'h0, txRoom = 22'h0, go = 22'h0;
    logic [21:0] wordDone, chanActive;
    logic spiHighPri = 1'b0, audioHighPri = 1'b0, irqAck = 1'b0, slow = 1'b0, irqReq;
    dmacil_pkg::dmacil_irqvec_t irqMask = 27'h0, irqClear = 27'h0, irqLatch;
    logic [7:0] audioInputChannelActive, irqVector;
    int error_cnt = 0, comparisons = 0, cycles = 0;
    int serBit [6] = '{24, 0, 25, 1, 26, 2};
    logic [7:0] serVec [6] = '{8'h38, 8'h44, 8'h3C, 8'h48, 8'h40, 8'h4C};

    dmacil_top dut (.clock(clock), .rst_b(rst_b), .chProg(chProg), .wordDone(wordDone),
        .chainReload(chainReload), .rxAvail(rxAvail), .txRoom(txRoom),
        .spiHighPri(spiHighPri), .audioHighPri(audioHighPri), .irqMask(irqMask),
        .irqClear(irqClear), .irqAck(irqAck), .chanActive(chanActive),
        .audioInputChannelActive(audioInputChannelActive), .irqLatch(irqLatch),
        .irqReq(irqReq), .irqVector(irqVector));
    dmacil_periph_model peer (.clock(clock), .rst_b(rst_b), .go(go), .slow(slow),
        .chanActive(chanActive), .wordDone(wordDone));

    always #50 clock = ~clock;
    // whole run needs well under 3000 cycles
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            error_cnt++;
            close_out();
        end
    end

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic tick(input int n = 1);
        repeat (n) @(posedge clock);
        #10;
    endtask
    task automatic check(input string what, input logic [34:0] exp, input logic [34:0] got);
        comparisons++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    // what: 1 count write, 2 chain pointer write, 3 chain reload
    task automatic prog(input int ch, input int what, input logic [19:0] v);
        chProg[ch].cntData = v[15:0];
        chProg[ch].cpData = v;
        chProg[ch].cntWrite = what == 1;
        chProg[ch].cpWrite = what == 2;
        chainReload[ch] = what == 3;
        tick();
        chProg[ch].cntWrite = 1'b0;
        chProg[ch].cpWrite = 1'b0;
        chainReload[ch] = 1'b0;
    endtask
    task automatic wait_bits(input logic [26:0] m, input int limit);
        for (int k = 0; k < limit && (irqLatch & m) !== m; k++)
            tick();
    endtask
    // expected {vector, latch bits} for one channel's completion
    function automatic logic [34:0] exp_map(input int ch, input logic spiH, input logic audH);
        logic [26:0] m;
        m = 27'h0;
        if (ch < 12)
        begin
            m[serBit[ch/2]] = 1'b1;
            return {serVec[ch/2], m};
        end
        if (ch == 20)
        begin
            m[spiH ? 22 : 9] = 1'b1;
            return {spiH ? 8'h30 : 8'h74, m};
        end
        if (ch == 21)
        begin
            m[3] = 1'b1;
            return {8'h50, m};
        end
        m[audH ? 21 : 6] = 1'b1;
        return {audH ? 8'h2C : 8'h5C, m};
    endfunction

    initial
    begin
        int n;
        logic [34:0] e;
        logic seen;
        foreach (chProg[i])
            chProg[i] = '0;
        n = $urandom(32'hfe44d49b);
        tick(5);
        rst_b = 1'b1;
        tick();
        check("reset", 35'h0, {irqVector, irqLatch});
        check("reset status", 35'h0, {irqReq, chanActive});
        $display("test reset done");
        for (int ch = 0; ch < 22; ch++)
        begin
            spiHighPri = 1'($urandom_range(1, 0));
            audioHighPri = 1'($urandom_range(1, 0));
            slow = 1'($urandom_range(1, 0));
            e = exp_map(ch, spiHighPri, audioHighPri);
            irqMask = e[26:0];
            go[ch] = 1'b1;
            chProg[ch].enable = 1'b1;
            prog(ch, 1, 20'($urandom_range(6, 1)));
            seen = 1'b0;
            for (int k = 0; k < 60 && irqLatch === 27'h0; k++)
            begin
                tick();
                seen |= chanActive[ch];
                if (audioInputChannelActive !== chanActive[19:12])
                    seen = 1'b0;
            end
            check("latch map", e[26:0], irqLatch);
            check("active seen", 35'h1, seen);
            if (ch >= 12 && ch < 20)
                check("audio active", 35'h1, 35'(audioInputChannelActive[ch - 12]));
            tick(2);
            check("vector", {e[34:27], 1'b1}, {irqVector, irqReq});
            check("active cleared", 35'h0, chanActive[ch]);
            irqClear = e[26:0];
            go = 22'h0;
            chProg[ch].enable = 1'b0;
            tick();
            irqClear = 27'h0;
            tick();
            check("cleared", 35'h0, irqLatch);
        end
        $display("test channel map done");
        spiHighPri = 1'b0;
        irqMask = 27'h0;
        rxAvail = 22'h300001;
        tick();
        rxAvail = 22'h0;
        txRoom = 22'h00000C;
        tick();
        txRoom = 22'h0;
        tick(10);
        e = exp_map(0, 0, 0) | exp_map(2, 0, 0) | exp_map(20, 0, 0) | exp_map(21, 0, 0);
        check("events latched masked", {e[26:0], 1'b0}, {irqLatch, irqReq});
        irqMask = 27'h7FFFFFF;
        tick(2);
        check("unmasked", {8'h38, 1'b1}, {irqVector, irqReq});
        irqAck = 1'b1;
        tick();
        irqAck = 1'b0;
        tick();
        check("acked", e[26:0] & 27'h2FFFFFF, irqLatch);
        irqClear = 27'h7FFFFFF;
        tick();
        irqClear = 27'h0;
        $display("test events done");
        slow = 1'b1;
        go[21] = 1'b1;
        chProg[21].enable = 1'b1;
        prog(21, 1, 20'd200);
        tick(8);
        prog(21, 1, 20'd0);
        tick(20);
        check("zero write", 35'h0, {chanActive[21], irqLatch});
        prog(21, 1, 20'd200);
        tick(9);
        prog(21, 1, 20'd1);
        n = 0;
        for (int k = 0; k < 40 && !irqLatch.second[3]; k++)
        begin
            n += int'(wordDone[21]);
            tick();
        end
        check("stop words", {1'b1, 32'd1}, {irqLatch.second[3], n});
        irqClear = 27'h7FFFFFF;
        go = 22'h0;
        chProg[21].enable = 1'b0;
        tick();
        irqClear = 27'h0;
        $display("test early stop done");
        slow = 1'b0;
        go[0] = 1'b1;
        chProg[0].enable = 1'b1;
        chProg[0].chainEn = 1'b1;
        prog(0, 2, 20'h00010);
        prog(0, 1, 20'd2);
        tick(30);
        check("chain pci clear", 35'h0, irqLatch);
        prog(0, 2, 20'h80010);
        prog(0, 3, 20'd2);
        wait_bits(27'h1000000, 30);
        check("chain pci set", 35'h1000000, irqLatch);
        irqClear = 27'h7FFFFFF;
        prog(0, 2, 20'h00000);
        irqClear = 27'h0;
        prog(0, 3, 20'd2);
        wait_bits(27'h1000000, 30);
        check("chain end", 35'h1000000, irqLatch);
        $display("test chain done");
        close_out();
    end
endmodule
`default_nettype wire
